// File: design/ssc_pkg.sv
// Purpose: Shared constants and carriers for the serial shift/counter port
// Assumes: One instruction cycle equals one clk_sys period
// Notes: Register width is one nibble, as in the accumulator

// ****************************************************************
// Package
// ****************************************************************
package ssc_pkg;

  localparam int RegWidth = 4;
  localparam int FifoDepth = 8;
  localparam int FifoPtrW = 3;

  // Least low time of a counted input pulse, in instruction cycles
  localparam int MinLowCycles = 2;

  // Reset values and last bit index
  localparam logic [3:0] RegReset = 4'h0;
  localparam logic LatchReset = 1'b0;
  localparam logic [1:0] LowCntReset = 2'h0;
  localparam logic [2:0] BitCntReset = 3'h0;
  localparam logic [3:0] LastBitIdx = 4'h3;

  typedef logic [RegWidth-1:0] ssc_nibble_t;

  // Exchange request: accumulator value and carry flag
  typedef struct packed {
    ssc_nibble_t acc;
    logic carry;
  } ssc_xch_s;

  // Port operating mode, taken from the mode select bit
  typedef enum logic {
    SSC_SHIFT,
    SSC_COUNT
  } ssc_mode_e;

endpackage

// File: design/ssc_serial_port.sv
// Purpose: Serial shift register / binary counter with clock-out logic
// Assumes: serialIn is asynchronous; linkClk is unrelated to clk_sys
// Notes: Exchange results leave through an 8-word FIFO and out register
//
// Contract
// - Exchange copies carry into clock latch; set latch routes sync clock out.
// - Mode select bit overrides latch-enabled sync clock at clock-out pin.
// - Latch set with counter mode drives clock-out pin static high.
// - Counter to shift change with latch set emits sync pulses at once.
// - Counter decrements per falling input edge held low two cycles.
// - Shift mode with latch set keeps shifting input bits in, overwriting older contents.
// - Exchange swaps register and accumulator in one operation.
// - Counter mode with steady input keeps the stored value unchanged.

// ****************************************************************
// FIFO
// ****************************************************************
module ssc_fifo #(
  parameter int Width = 4,
  parameter int Depth = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic inValid,
  output logic inReady,
  input wire logic [Width-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [Width-1:0] outData
);

  // Count has one bit more than the pointers to tell full from empty
  localparam int PtrW = $clog2(Depth);

  logic [Width-1:0] mem [Depth];
  logic [PtrW-1:0] wrPtr_q;
  logic [PtrW-1:0] rdPtr_q;
  logic [PtrW:0] count_q;
  logic push;
  logic pop;

  assign inReady = (count_q != (PtrW+1)'(Depth));
  assign outValid = (count_q != '0);
  assign outData = mem[rdPtr_q];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule

// ****************************************************************
// Serial port core
// ****************************************************************
module ssc_serial_port (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic linkClk,
  input wire logic linkReset,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialClockOut,
  input wire logic serialModeSelectBit,
  input wire logic xchValid,
  output logic xchReady,
  input wire ssc_pkg::ssc_xch_s xchReq,
  output logic accValid,
  input wire logic accReady,
  output ssc_pkg::ssc_nibble_t accOut,
  output ssc_pkg::ssc_nibble_t serialShiftRegister,
  output logic serialClockLatch,
  output logic linkNibbleValid,
  output ssc_pkg::ssc_nibble_t linkNibble
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  ssc_pkg::ssc_nibble_t reg_q;
  logic latch_q;
  logic sync_q;
  logic clkOut_q;
  logic serOut_q;
  logic siMeta_q;
  logic siSync_q;
  logic [1:0] siHist_q;
  ssc_pkg::ssc_mode_e mode;
  logic xchTake;
  logic shiftNow;
  logic countNow;
  logic fifoInReady;
  logic fifoOutValid;
  ssc_pkg::ssc_nibble_t fifoOutData;
  logic fifoPop;
  logic accValid_q;
  ssc_pkg::ssc_nibble_t accOut_q;
  logic xchReady_q;
  logic [2:0] bitCnt_q;
  ssc_pkg::ssc_nibble_t hold_q;
  logic reqTgl_q;
  logic ackMeta_q;
  logic ackSync_q;
  logic reqMeta_q;
  logic reqSync_q;
  logic reqSeen_q;
  logic ackTgl_q;
  ssc_pkg::ssc_nibble_t linkNib_q;
  logic linkVal_q;
  logic holdBusy;

  function automatic ssc_pkg::ssc_nibble_t shiftIn(
    input ssc_pkg::ssc_nibble_t cur,
    input logic bitIn
  );
    shiftIn = {cur[2:0], bitIn};
  endfunction

  // ****************************************************************
  // Input synchroniser and mode
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      siMeta_q <= 1'b0;
      siSync_q <= 1'b0;
      siHist_q <= ssc_pkg::LowCntReset;
    end else begin
      siMeta_q <= serialIn;
      siSync_q <= siMeta_q;
      siHist_q <= {siHist_q[0], siSync_q};
    end
  end

  assign mode = serialModeSelectBit ? ssc_pkg::SSC_COUNT : ssc_pkg::SSC_SHIFT;

  // Edge counts only once the low level has been seen on two cycles
  assign countNow = (mode == ssc_pkg::SSC_COUNT) &&
    siHist_q[1] && !siHist_q[0] && !siSync_q;

  // Shift on the falling edge of each emitted clock-out pulse.
  // The pin is loaded from !sync_q, so it matches sync_q; pin high while
  // sync_q is high means the pin falls at this edge. A pin held high
  // from counter mode falls on the first such edge, never earlier.
  assign shiftNow = (mode == ssc_pkg::SSC_SHIFT) && latch_q &&
    clkOut_q && sync_q;

  assign xchTake = xchValid && xchReady_q;

  // ****************************************************************
  // Clock latch and clock-out pin
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      latch_q <= ssc_pkg::LatchReset;
    end else if (xchTake) begin
      latch_q <= xchReq.carry;
    end
  end

  // Sync clock is clk_sys divided by two; it runs free so that pulses
  // start on the next edge whatever the latch did before
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sync_q <= 1'b0;
    end else begin
      sync_q <= !sync_q;
    end
  end

  // Mode is read every cycle, so a change to shift mode with the latch
  // set starts pulses without waiting for another exchange
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      clkOut_q <= 1'b0;
    end else if (!latch_q) begin
      clkOut_q <= 1'b0;
    end else if (mode == ssc_pkg::SSC_COUNT) begin
      clkOut_q <= 1'b1;
    end else begin
      clkOut_q <= !sync_q;
    end
  end

  // ****************************************************************
  // Serial register
  // ****************************************************************
  // Exchange wins over a shift or count in the same cycle
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reg_q <= ssc_pkg::RegReset;
    end else if (xchTake) begin
      reg_q <= xchReq.acc;
    end else if (shiftNow) begin
      reg_q <= shiftIn(reg_q, siSync_q);
    end else if (countNow) begin
      reg_q <= reg_q - 1'b1;
    end
  end

  // Outgoing bit lags the register by one cycle; it still stands for
  // a whole shift period, as shifts come every second cycle
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      serOut_q <= 1'b0;
    end else if (mode == ssc_pkg::SSC_SHIFT) begin
      serOut_q <= reg_q[ssc_pkg::LastBitIdx[1:0]];
    end else begin
      serOut_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Exchange result path
  // ****************************************************************
  // Request is refused while the FIFO is full, so no result is lost.
  // Ready drops for a cycle after each take; this keeps the full
  // check one word ahead of the push that it guards.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      xchReady_q <= 1'b0;
    end else begin
      xchReady_q <= fifoInReady && !(xchValid && xchReady_q);
    end
  end

  ssc_fifo #(
    .Width(ssc_pkg::RegWidth),
    .Depth(ssc_pkg::FifoDepth)
  ) u_fifo (
    .clk_sys(clk_sys),
    .reset(reset),
    .inValid(xchTake),
    .inReady(fifoInReady),
    .inData(reg_q),
    .outValid(fifoOutValid),
    .outReady(fifoPop),
    .outData(fifoOutData)
  );

  assign fifoPop = fifoOutValid && (!accValid_q || accReady);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      accValid_q <= 1'b0;
      accOut_q <= ssc_pkg::RegReset;
    end else if (fifoPop) begin
      accValid_q <= 1'b1;
      accOut_q <= fifoOutData;
    end else if (accReady) begin
      accValid_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Nibble hand-off to link domain
  // ****************************************************************
  // Full nibbles are offered by toggle handshake; while one is in
  // flight later nibbles are skipped, as the link is much slower
  assign holdBusy = (reqTgl_q != ackSync_q);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bitCnt_q <= ssc_pkg::BitCntReset;
      hold_q <= ssc_pkg::RegReset;
      reqTgl_q <= 1'b0;
      ackMeta_q <= 1'b0;
      ackSync_q <= 1'b0;
    end else begin
      ackMeta_q <= ackTgl_q;
      ackSync_q <= ackMeta_q;
      if (xchTake) begin
        bitCnt_q <= ssc_pkg::BitCntReset;
      end else if (shiftNow) begin
        if (bitCnt_q == ssc_pkg::LastBitIdx[2:0]) begin
          bitCnt_q <= ssc_pkg::BitCntReset;
          if (!holdBusy) begin
            hold_q <= shiftIn(reg_q, siSync_q);
            reqTgl_q <= !reqTgl_q;
          end
        end else begin
          bitCnt_q <= bitCnt_q + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge linkClk or posedge linkReset) begin
    if (linkReset) begin
      reqMeta_q <= 1'b0;
      reqSync_q <= 1'b0;
      reqSeen_q <= 1'b0;
      ackTgl_q <= 1'b0;
      linkNib_q <= ssc_pkg::RegReset;
      linkVal_q <= 1'b0;
    end else begin
      reqMeta_q <= reqTgl_q;
      reqSync_q <= reqMeta_q;
      reqSeen_q <= reqSync_q;
      linkVal_q <= reqSync_q != reqSeen_q;
      if (reqSync_q != reqSeen_q) begin
        linkNib_q <= hold_q;
        ackTgl_q <= reqSync_q;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign serialOut = serOut_q;
  assign serialClockOut = clkOut_q;
  assign xchReady = xchReady_q;
  assign accValid = accValid_q;
  assign accOut = accOut_q;
  assign serialShiftRegister = reg_q;
  assign serialClockLatch = latch_q;
  assign linkNibbleValid = linkVal_q;
  assign linkNibble = linkNib_q;

endmodule

// File: verif/ssc_pulse_src.sv
// Purpose: Far-side source for the serial input pin
// Assumes: Pulses are requested by the bench one at a time
// Notes: Holds a steady level between pulses
// ****************************************************************
// Pulse source
// ****************************************************************
module ssc_pulse_src (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic level,
  input wire logic go,
  input wire logic [3:0] lowLen,
  output logic serialIn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] lowCnt;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      lowCnt <= 4'h0;
    end else if (go) begin
      lowCnt <= lowLen;
    end else if (lowCnt != 4'h0) begin
      lowCnt <= lowCnt - 4'h1;
    end
  end
  // Steady level outside pulses keeps a counter value intact
  assign serialIn = (lowCnt != 4'h0) ? 1'b0 : level;
endmodule

// File: verif/ssc_serial_port_sva.sv
// Purpose: Port checks of the serial shift/counter port
// Assumes: All checked signals sit in the clk_sys domain
// Notes: Link-side outputs are judged by the bench
// ****************************************************************
// Checker
// ****************************************************************
module ssc_chk (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic serialIn,
  input wire logic serialOut,
  input wire logic serialClockOut,
  input wire logic serialModeSelectBit,
  input wire logic xchValid,
  input wire logic xchReady,
  input wire ssc_pkg::ssc_xch_s xchReq,
  input wire ssc_pkg::ssc_nibble_t serialShiftRegister,
  input wire logic serialClockLatch
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic take;
  logic isCnt;
  logic shf;
  logic [2:0] quietQ;
  assign take = xchValid && xchReady;
  assign isCnt = serialModeSelectBit;
  assign shf = serialClockLatch && !serialModeSelectBit;
  // Quiet time covers the input synchroniser and pulse history
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      quietQ <= 3'h0;
    end else if ($changed(serialIn) || $changed(isCnt)) begin
      quietQ <= 3'h0;
    end else if (quietQ != 3'h7) begin
      quietQ <= quietQ + 3'h1;
    end
  end
  sequence sTake;
    xchValid && xchReady;
  endsequence
  sequence sToggle;
    serialClockOut != $past(serialClockOut);
  endsequence
  AST_XCH_LATCH: assert property (sTake |=>
    serialClockLatch == $past(xchReq.carry)) else $error("latch load");
  AST_XCH_SWAP: assert property (sTake |=>
    serialShiftRegister == $past(xchReq.acc)) else $error("swap");
  AST_CNT_HIGH: assert property (isCnt && serialClockLatch
    && $past(isCnt && serialClockLatch) |-> serialClockOut)
    else $error("clock out not high");
  AST_SHF_TOGGLE: assert property (shf [*3] |-> sToggle)
    else $error("clock out not toggling");
  AST_START_NOW: assert property ($fell(isCnt) && serialClockLatch
    && serialClockOut |-> ##[1:2] !serialClockOut)
    else $error("pulses late");
  AST_DEC: assert property (isCnt && $past(isCnt) && $past(isCnt, 2)
    && !$past(take) && $changed(serialShiftRegister) |->
    serialShiftRegister == $past(serialShiftRegister) - 4'h1)
    else $error("bad decrement");
  AST_HOLD: assert property (isCnt && quietQ == 3'h7 && !$past(take)
    |-> $stable(serialShiftRegister)) else $error("value lost");
  AST_SHIFT: assert property (shf && $past(shf) && !$past(take)
    && $changed(serialShiftRegister) |-> serialShiftRegister[3:1]
    == $past(serialShiftRegister[2:0])) else $error("bad shift");
  AST_OUT_BIT: assert property (!isCnt && $past(!isCnt) |->
    serialOut == $past(serialShiftRegister[3])) else $error("out bit");
endmodule
bind ssc_serial_port ssc_chk u_chk (.clk_sys, .reset, .serialIn,
  .serialOut, .serialClockOut, .serialModeSelectBit, .xchValid,
  .xchReady, .xchReq, .serialShiftRegister, .serialClockLatch);

// File: verif/tb_ssc_serial_port.sv
// Purpose: Directed bench of the serial shift/counter port
// Assumes: Inputs change 1 ns after the rising clk_sys edge
// Notes: Return FIFO is filled with the consumer stalled
// ****************************************************************
// Bench
// ****************************************************************
module tb_ssc_serial_port;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 0, linkClk = 0, reset = 1, serialModeSelectBit = 1;
  logic xchValid = 0, accReady = 1, level = 1, go = 0, ok;
  logic [3:0] lowLen = 4'h0;
  ssc_pkg::ssc_xch_s xchReq = '0;
  logic serialIn, serialOut, serialClockOut, xchReady, accValid;
  logic serialClockLatch, linkNibbleValid;
  ssc_pkg::ssc_nibble_t accOut, serialShiftRegister, linkNibble;
  int n_mismatch = 0, n_tests = 0, taken = 0;
  initial forever #4 clk_sys = ~clk_sys;
  initial #3 forever #62.5 linkClk = ~linkClk;
  ssc_pulse_src src (.clk_sys, .reset, .level, .go, .lowLen, .serialIn);
  ssc_serial_port uut (.clk_sys, .reset, .linkClk, .linkReset(reset),
    .serialIn, .serialOut, .serialClockOut, .serialModeSelectBit,
    .xchValid, .xchReady, .xchReq, .accValid, .accReady, .accOut,
    .serialShiftRegister, .serialClockLatch, .linkNibbleValid,
    .linkNibble);
  task chk(input logic [3:0] seen, input logic [3:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task xch(input logic [3:0] a, input logic c);
    int k;
    k = 0;
    ok = 0;
    xchReq = '{acc: a, carry: c};
    xchValid = 1;
    // Ready is read settled, before the edge that takes the request
    while (!ok && k < 20) begin
      ok = (xchReady === 1'b1);
      @(posedge clk_sys);
      #1;
      k++;
    end
    xchValid = 0;
    cyc(1);
  endtask
  task getAcc(input logic [3:0] exp);
    for (int k = 0; k < 20 && accValid !== 1'b1; k++) cyc(1);
    chk(accValid, 1'b1);
    chk(accOut, exp);
    cyc(1);
  endtask
  task pulse(input logic [3:0] n);
    lowLen = n;
    go = 1;
    cyc(1);
    go = 0;
    cyc(12);
  endtask
  task summarize();
    $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Run is a few hundred cycles; the limit leaves ample margin
  initial begin
    #60us;
    n_mismatch++;
    summarize();
  end
  initial begin
    cyc(5);
    chk(serialShiftRegister, 4'h0);
    chk({serialClockLatch, serialClockOut, accValid}, 4'h0);
    reset = 0;
    $display("test reset done");
    xch(4'h9, 1'b1);
    getAcc(4'h0);
    cyc(12);
    chk(serialClockLatch, 1'b1);
    chk(serialClockOut, 1'b1);
    chk(serialShiftRegister, 4'h9);
    pulse(4'h3);
    pulse(4'h2);
    pulse(4'h1);
    chk(serialShiftRegister, 4'h7);
    $display("test counter done");
    serialModeSelectBit = 0;
    for (int i = 0; i < 20 && linkNibbleValid !== 1'b1; i++) begin
      @(posedge linkClk);
      #1;
    end
    chk(linkNibbleValid, 1'b1);
    chk(linkNibble, 4'hF);
    cyc(1);
    chk(serialShiftRegister, 4'hF);
    chk(serialOut, 1'b1);
    xch(4'h0, 1'b1);
    getAcc(4'hF);
    level = 0;
    cyc(20);
    chk(serialShiftRegister, 4'h0);
    chk(serialOut, 1'b0);
    $display("test shift done");
    serialModeSelectBit = 1;
    level = 1;
    accReady = 0;
    cyc(10);
    for (int k = 1; k <= 10; k++) begin
      xch(k[3:0], 1'b0);
      taken += int'(ok);
    end
    chk(taken[3:0], 4'h9);
    accReady = 1;
    getAcc(4'h0);
    for (int k = 1; k <= 8; k++) getAcc(k[3:0]);
    chk(serialShiftRegister, 4'h9);
    $display("test buffer done");
    summarize();
  end
endmodule
